// [core/flarc_top.sv]
module flarc_top
  import flarc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = FLARC_CYC_PER_MS
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic FAULT_EVENT_I,
  input wire logic [7:0] FAULT_BYTE_I,
  input wire logic [39:0] ALARM_LOG_I,
  input wire logic [7:0] SENSE_BYTE_I,
  input wire logic [7:0] SENSE_MIN_BYTE_I,
  input wire logic [7:0] SENSE_MAX_BYTE_I,
  input wire logic [7:0] SUPPLY_SAMPLE_BYTE_I,
  input wire logic [7:0] SUPPLY_MIN_BYTE_I,
  input wire logic [7:0] SUPPLY_MAX_BYTE_I,
  output logic EE_WR_REQ_O,
  output logic [7:0] EE_ADDR_O,
  output logic [7:0] EE_DATA_O,
  input wire logic EE_WR_ACK_I,
  output logic LOG_ALERT_O,
  input wire logic RESTART_CMD_I,
  input wire logic COOLING_ACTIVE_I,
  input wire logic LATCHED_OFF_I,
  input wire logic WP_PIN_I,
  output logic RESTART_O
);

  localparam int unsigned IDX_W = $clog2(FLARC_LOG_BYTES);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(FLARC_LOG_BYTES - 1);

  // Register bits
  logic arm_q;
  logic arm_d;
  logic permit_q;
  logic permit_d;
  logic begun_q;
  logic begun_d;
  logic finished_q;
  logic finished_d;
  logic irq_en_q;
  logic irq_en_d;
  logic rs_en_q;
  logic rs_en_d;
  logic [2:0] rs_sel_q;
  logic [2:0] rs_sel_d;
  logic rearm_q;
  logic rearm_d;
  logic wp_s1_q;
  logic wp_s2_q;

  // Bus side
  logic wr_fr;
  logic wr_rs;
  logic rd_fr;
  logic rd_rs;
  logic [7:0] fr_view;
  logic [7:0] rs_view;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic rvalid_q;

  // Log sequencer
  flarc_log_state_type state_q;
  flarc_log_state_type state_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic ee_req_q;
  logic ee_req_d;
  logic [7:0] ee_addr_q;
  logic [7:0] ee_addr_d;
  logic [7:0] ee_data_q;
  logic [7:0] ee_data_d;
  logic log_start;
  logic log_finish;
  logic alert_q;
  logic [7:0] snap_in [FLARC_LOG_BYTES];
  logic [7:0] snap_q [FLARC_LOG_BYTES];

  // Restart path
  logic rs_fresh_arm;
  logic rs_launch;
  logic tmr_busy;
  logic tmr_done;
  logic delay_active;
  logic restart_q;

  assign wr_fr = REG_WR_I && (REG_ADDR_I == FLARC_REG_FAULT_REC);
  assign wr_rs = REG_WR_I && (REG_ADDR_I == FLARC_REG_RESTART);
  assign rd_fr = REG_ADDR_I == FLARC_REG_FAULT_REC;
  assign rd_rs = REG_ADDR_I == FLARC_REG_RESTART;

  // Arm and control bits follow host writes only
  assign arm_d = wr_fr ? REG_WDATA_I[FLARC_FR_ARM_BIT] : arm_q;
  assign permit_d = wr_fr ? REG_WDATA_I[FLARC_FR_PERMIT_BIT] : permit_q;
  assign irq_en_d = wr_fr ? REG_WDATA_I[FLARC_FR_IRQ_EN_BIT] : irq_en_q;

  // Begun set by hardware, set beats a host clear
  always_comb begin
    begun_d = begun_q;
    if (log_start) begin
      begun_d = 1'b1;
    end else if (wr_fr && permit_q && !REG_WDATA_I[FLARC_FR_BEGUN_BIT]) begin
      begun_d = 1'b0;
    end
  end

  // Finished set by hardware, host may only clear
  always_comb begin
    finished_d = finished_q;
    if (log_finish) begin
      finished_d = 1'b1;
    end else if (wr_fr && permit_q && !REG_WDATA_I[FLARC_FR_FINISHED_BIT]) begin
      finished_d = 1'b0;
    end
  end

  assign log_start = (state_q == FLARC_LOG_IDLE) && FAULT_EVENT_I && arm_q && !begun_q && !finished_q;

  assign snap_in[0] = FAULT_BYTE_I;
  for (genvar a = 0; a < FLARC_ALARM_BYTES; a++) begin : g_alarm
    assign snap_in[1 + a] = ALARM_LOG_I[8 * a +: 8];
  end
  assign snap_in[6] = SENSE_BYTE_I;
  assign snap_in[7] = SENSE_MIN_BYTE_I;
  assign snap_in[8] = SENSE_MAX_BYTE_I;
  assign snap_in[9] = SUPPLY_SAMPLE_BYTE_I;
  assign snap_in[10] = SUPPLY_MIN_BYTE_I;
  assign snap_in[11] = SUPPLY_MAX_BYTE_I;

  // Snapshot taken at start, so later changes do not tear the record
  for (genvar i = 0; i < FLARC_LOG_BYTES; i++) begin : g_snap
    always_ff @(posedge CORE_CLK_I) begin
      if (!RESETN_I) begin
        snap_q[i] <= 8'h00;
      end else if (log_start) begin
        snap_q[i] <= snap_in[i];
      end
    end
  end

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    ee_req_d = ee_req_q;
    ee_addr_d = ee_addr_q;
    ee_data_d = ee_data_q;
    log_finish = 1'b0;
    case (state_q)
      FLARC_LOG_IDLE: begin
        if (log_start) begin
          idx_d = '0;
          state_d = FLARC_LOG_LOAD;
        end
      end
      FLARC_LOG_LOAD: begin
        ee_req_d = 1'b1;
        ee_addr_d = FLARC_EE_ADDR[idx_q];
        ee_data_d = snap_q[idx_q];
        state_d = FLARC_LOG_WRITE;
      end
      FLARC_LOG_WRITE: begin
        if (EE_WR_ACK_I) begin
          ee_req_d = 1'b0;
          if (idx_q == IDX_LAST) begin
            log_finish = 1'b1;
            state_d = FLARC_LOG_IDLE;
          end else begin
            idx_d = idx_q + IDX_W'(1);
            state_d = FLARC_LOG_LOAD;
          end
        end
      end
      default: begin
        ee_req_d = 1'b0;
        state_d = FLARC_LOG_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state_q <= FLARC_LOG_IDLE;
      idx_q <= '0;
      ee_req_q <= 1'b0;
      ee_addr_q <= 8'h00;
      ee_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      ee_req_q <= ee_req_d;
      ee_addr_q <= ee_addr_d;
      ee_data_q <= ee_data_d;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= log_finish && irq_en_q;
    end
  end

  assign rs_fresh_arm = wr_rs && REG_WDATA_I[FLARC_RS_EN_BIT] && !rs_en_q;
  assign rs_launch = RESTART_CMD_I && rs_en_q && rearm_q && !tmr_busy;
  assign rearm_d = rs_fresh_arm ? 1'b1 : (rs_launch ? 1'b0 : rearm_q);

  // Enable changes by host write only
  assign rs_en_d = wr_rs ? REG_WDATA_I[FLARC_RS_EN_BIT] : rs_en_q;
  assign rs_sel_d = wr_rs ? REG_WDATA_I[FLARC_RS_SEL_MSB:FLARC_RS_SEL_LSB] : rs_sel_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      arm_q <= FLARC_REG_RESET_VAL[FLARC_FR_ARM_BIT];
      permit_q <= FLARC_REG_RESET_VAL[FLARC_FR_PERMIT_BIT];
      begun_q <= FLARC_REG_RESET_VAL[FLARC_FR_BEGUN_BIT];
      finished_q <= FLARC_REG_RESET_VAL[FLARC_FR_FINISHED_BIT];
      irq_en_q <= FLARC_REG_RESET_VAL[FLARC_FR_IRQ_EN_BIT];
      rs_en_q <= FLARC_REG_RESET_VAL[FLARC_RS_EN_BIT];
      rs_sel_q <= FLARC_RS_SEL_RESET;
      rearm_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      permit_q <= permit_d;
      begun_q <= begun_d;
      finished_q <= finished_d;
      irq_en_q <= irq_en_d;
      rs_en_q <= rs_en_d;
      rs_sel_q <= rs_sel_d;
      rearm_q <= rearm_d;
    end
  end

  // Selected delay counted from command; dropping the enable aborts it
  flarc_restart_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .start_i(rs_launch),
    .abort_i(!rs_en_q),
    .sel_i(rs_sel_q),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= tmr_done && rs_en_q;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      wp_s1_q <= WP_PIN_I;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign delay_active = tmr_busy || COOLING_ACTIVE_I || LATCHED_OFF_I;

  assign fr_view = {arm_q, permit_q, begun_q, finished_q, irq_en_q, 3'h0};
  assign rs_view = {rs_en_q, rs_sel_q, 2'h0, delay_active, wp_s2_q};
  assign rd_mux = rd_fr ? fr_view : (rd_rs ? rs_view : 8'h00);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD_I;
      if (REG_RD_I) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign REG_RVALID_O = rvalid_q;
  assign EE_WR_REQ_O = ee_req_q;
  assign EE_ADDR_O = ee_addr_q;
  assign EE_DATA_O = ee_data_q;
  assign LOG_ALERT_O = alert_q;
  assign RESTART_O = restart_q;

endmodule // flarc_top

// [core/flarc_pkg.sv]
package flarc_pkg;

  // Register offsets on the host register port, and the register reset value
  localparam logic [7:0] FLARC_REG_FAULT_REC = 8'h90;
  localparam logic [7:0] FLARC_REG_RESTART = 8'hA2;
  localparam logic [7:0] FLARC_REG_RESET_VAL = 8'h00;

  // fault_record_control fields
  localparam int unsigned FLARC_FR_ARM_BIT = 7;
  localparam int unsigned FLARC_FR_PERMIT_BIT = 6;
  localparam int unsigned FLARC_FR_BEGUN_BIT = 5;
  localparam int unsigned FLARC_FR_FINISHED_BIT = 4;
  localparam int unsigned FLARC_FR_IRQ_EN_BIT = 3;

  // restart_control fields
  localparam int unsigned FLARC_RS_EN_BIT = 7;
  localparam int unsigned FLARC_RS_SEL_MSB = 6;
  localparam int unsigned FLARC_RS_SEL_LSB = 4;
  localparam int unsigned FLARC_RS_ACTIVE_BIT = 1;
  localparam int unsigned FLARC_RS_WP_BIT = 0;
  localparam logic [2:0] FLARC_RS_SEL_RESET = 3'h0;

  // Recorded bytes and their storage addresses, in write order
  localparam int unsigned FLARC_LOG_BYTES = 12;
  localparam int unsigned FLARC_ALARM_BYTES = 5;
  localparam logic [7:0] FLARC_EE_ADDR [FLARC_LOG_BYTES] = '{
    8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9,
    8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6};

  // Restart delay per selection, in milliseconds
  localparam int unsigned FLARC_RESTART_DELAY_TIME_MS [8] = '{
    512, 1020, 2050, 4100, 8190, 16400, 32800, 65500};
  localparam int unsigned FLARC_CLK_HZ = 40_000_000;
  localparam int unsigned FLARC_CYC_PER_MS = FLARC_CLK_HZ / 1000;

  typedef enum logic [1:0] {
    FLARC_LOG_IDLE,
    FLARC_LOG_LOAD,
    FLARC_LOG_WRITE
  } flarc_log_state_type;

endpackage : flarc_pkg

// [core/flarc_restart_timer.sv]
module flarc_restart_timer
  import flarc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = FLARC_CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [2:0] sel_i,
  output logic busy_o,
  output logic done_o
);

  // Longest delay must fit the 32-bit down counter
  if (CYC_PER_MS < 1 || 64'(CYC_PER_MS) * 64'(FLARC_RESTART_DELAY_TIME_MS[7]) > 64'hFFFF_FFFF) begin : g_chk
    $error("flarc_restart_timer: CYC_PER_MS out of range");
  end

  logic [63:0] prod;
  logic [31:0] load_val;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic expire;

  assign prod = 64'(FLARC_RESTART_DELAY_TIME_MS[sel_i]) * 64'(CYC_PER_MS);
  assign load_val = prod[31:0] - 32'h0000_0001;
  assign expire = busy_q && (cnt_q == 32'h0000_0000);

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort_i) begin
      busy_d = 1'b0;
    end else if (start_i && !busy_q) begin
      cnt_d = load_val;
      busy_d = 1'b1;
    end else if (expire) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end else if (busy_q) begin
      cnt_d = cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;

endmodule // flarc_restart_timer

// [bench/flarc_top_asserts.sv]
module flarc_top_asserts
  import flarc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = FLARC_CYC_PER_MS
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic EE_WR_REQ_O,
  input wire logic [7:0] EE_ADDR_O,
  input wire logic [7:0] EE_DATA_O,
  input wire logic EE_WR_ACK_I,
  input wire logic LOG_ALERT_O,
  input wire logic RESTART_CMD_I,
  input wire logic WP_PIN_I,
  input wire logic RESTART_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] sel_q;
  logic [2:0] cmd_sel_q;
  logic [31:0] since_q;
  logic [31:0] lim;
  logic rd90;
  logic rda2;
  // Restart pulse is registered one cycle after the counted delay
  assign lim = 32'(FLARC_RESTART_DELAY_TIME_MS[cmd_sel_q] * CYC_PER_MS + 1);
  assign rd90 = REG_RD_I && (REG_ADDR_I == FLARC_REG_FAULT_REC);
  assign rda2 = REG_RD_I && (REG_ADDR_I == FLARC_REG_RESTART);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Mirror of the stored selection; ignored commands must not come mid-delay
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      sel_q <= 3'h0;
      cmd_sel_q <= 3'h0;
      since_q <= 32'h0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == FLARC_REG_RESTART) begin
        sel_q <= REG_WDATA_I[6:4];
      end
      if (RESTART_CMD_I) begin
        cmd_sel_q <= sel_q;
      end
      since_q <= RESTART_CMD_I ? 32'h0 : since_q + 32'h1;
    end
  end
  rsvd_fault_a: assert property (rd90 |=> REG_RVALID_O && REG_RDATA_O[2:0] == 3'h0)
    else $error("fault record reserved bits not zero");
  rsvd_restart_a: assert property (rda2 |=> REG_RVALID_O && REG_RDATA_O[3:2] == 2'h0)
    else $error("restart reserved bits not zero");
  unmapped_read_a: assert property (REG_RD_I && !rd90 && !rda2 |=> REG_RVALID_O && REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  wp_level_a: assert property (rda2 && $past(RESETN_I, 1) && $past(RESETN_I, 2)
    && $past(WP_PIN_I, 1) == $past(WP_PIN_I, 3) && $past(WP_PIN_I, 2) == $past(WP_PIN_I, 3)
    |=> REG_RDATA_O[0] == $past(WP_PIN_I, 3))
    else $error("write protect level wrong");
  ee_hold_a: assert property (EE_WR_REQ_O && !EE_WR_ACK_I
    |=> EE_WR_REQ_O && $stable(EE_ADDR_O) && $stable(EE_DATA_O))
    else $error("storage request dropped or changed");
  ee_gap_a: assert property (EE_WR_REQ_O && EE_WR_ACK_I |=> !EE_WR_REQ_O)
    else $error("request not lowered after ack");
  alert_src_a: assert property (LOG_ALERT_O |-> $past(EE_WR_ACK_I) && $past(EE_ADDR_O) == 8'hE6 ##1 !LOG_ALERT_O)
    else $error("alert not after last byte");
  restart_time_a: assert property (RESTART_O |-> since_q == lim)
    else $error("restart delay wrong");
  cover property (LOG_ALERT_O);
  cover property (RESTART_O);
  cover property (EE_WR_REQ_O && !EE_WR_ACK_I [*3]);
endmodule // flarc_top_asserts

// [bench/flarc_ee_model.sv]
module flarc_ee_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [3:0] lat_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [3:0] wait_q;
  int wcnt;
  initial begin
    ack_o = 1'b0;
    wait_q = 4'h0;
    wcnt = 0;
  end
  // Stall lat_i cycles per byte, then one ack pulse
  always @(posedge clk_i) begin
    if (req_i && !ack_o && wait_q == lat_i) begin
      ack_o <= 1'b1;
      mem[addr_i] <= data_i;
      wcnt <= wcnt + 1;
      wait_q <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // flarc_ee_model

// [bench/tb_top.sv]
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flarc_pkg::*;
  logic clk, rstn, wr, rd, fault, cmd, cool, latch, wp, rvalid, ee_req, ee_ack, alert, restart;
  logic [7:0] addr, wdata, k, rdata, ee_addr, ee_data;
  logic [3:0] lat;
  int fail_count, comparisons, cyc, alerts;
  logic [7:0] ev [12] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  flarc_top #(.CYC_PER_MS(1)) flarc_top_inst (
    .CORE_CLK_I(clk), .RESETN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .FAULT_EVENT_I(fault),
    .FAULT_BYTE_I(k ^ 8'h11), .ALARM_LOG_I({k ^ 8'h16, k ^ 8'h15, k ^ 8'h14, k ^ 8'h13, k ^ 8'h12}),
    .SENSE_BYTE_I(k ^ 8'h21), .SENSE_MIN_BYTE_I(k ^ 8'h22), .SENSE_MAX_BYTE_I(k ^ 8'h23),
    .SUPPLY_SAMPLE_BYTE_I(k ^ 8'h24), .SUPPLY_MIN_BYTE_I(k ^ 8'h25), .SUPPLY_MAX_BYTE_I(k ^ 8'h26),
    .EE_WR_REQ_O(ee_req), .EE_ADDR_O(ee_addr), .EE_DATA_O(ee_data), .EE_WR_ACK_I(ee_ack),
    .LOG_ALERT_O(alert), .RESTART_CMD_I(cmd), .COOLING_ACTIVE_I(cool), .LATCHED_OFF_I(latch),
    .WP_PIN_I(wp), .RESTART_O(restart));
  flarc_ee_model flarc_ee_model_inst (.clk_i(clk), .req_i(ee_req), .addr_i(ee_addr), .data_i(ee_data),
    .lat_i(lat), .ack_o(ee_ack));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (alert === 1'b1) alerts++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task conclude();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask
  task chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  // One-cycle strobe on the command or the fault input
  task pulse(input bit to_cmd);
    @(posedge clk);
    if (to_cmd) cmd <= 1'b1;
    else fault <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    fault <= 1'b0;
  endtask
  task cmd_wait(input bit go, input int e, input int lim);
    int n;
    n = 0;
    if (go) pulse(1'b1);
    while (n < lim) begin
      @(posedge clk);
      #1;
      n++;
      if (restart === 1'b1) break;
    end
    `CHK("restart cycles", e, n)
  endtask
  task run_log(input logic [7:0] kk, input logic [3:0] l, input int ea);
    int w0, a0, n;
    logic [7:0] d;
    w0 = flarc_ee_model_inst.wcnt;
    a0 = alerts;
    k <= kk;
    lat <= l;
    pulse(1'b0);
    rd_reg(8'h90, d);
    `CHK("begun", 2'h2, d[5:4])
    n = 0;
    while (d[4] !== 1'b1 && n < 100) begin
      rd_reg(8'h90, d);
      n++;
    end
    `CHK("writes", w0 + 12, flarc_ee_model_inst.wcnt)
    for (int i = 0; i < 12; i++) `CHK("ee byte", ev[i] ^ kk, flarc_ee_model_inst.mem[FLARC_EE_ADDR[i]])
    `CHK("alerts", a0 + ea, alerts)
  endtask
  task t_regs();
    chk_reg(8'h90, 8'h00);
    chk_reg(8'hA2, 8'h00);
    chk_reg(8'h55, 8'h00);
    wr_reg(8'h90, 8'hFF);
    chk_reg(8'h90, 8'hC8);
    wr_reg(8'hA2, 8'h7F);
    wp <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg(8'hA2, 8'h71);
    wp <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg(8'hA2, 8'h70);
    cool <= 1'b1;
    chk_reg(8'hA2, 8'h72);
    cool <= 1'b0;
    latch <= 1'b1;
    chk_reg(8'hA2, 8'h72);
    latch <= 1'b0;
    wr_reg(8'h90, 8'h00);
  endtask
  task t_log();
    int w0;
    wr_reg(8'h90, 8'h88);
    run_log(8'h00, 4'h0, 1);
    chk_reg(8'h90, 8'hB8);
    w0 = flarc_ee_model_inst.wcnt;
    pulse(1'b0);
    repeat (20) @(posedge clk);
    `CHK("no relog", w0, flarc_ee_model_inst.wcnt)
    wr_reg(8'h90, 8'h80);
    chk_reg(8'h90, 8'hB0);
    wr_reg(8'h90, 8'hC0);
    chk_reg(8'h90, 8'hF0);
    wr_reg(8'h90, 8'hC0);
    chk_reg(8'h90, 8'hC0);
    run_log(8'h5A, 4'h5, 0);
    wr_reg(8'h90, 8'h00);
    chk_reg(8'h90, 8'h00);
  endtask
  task t_restart();
    wr_reg(8'hA2, 8'h80);
    cmd_wait(1, 513, 600);
    chk_reg(8'hA2, 8'h80);
    // Writing one over a standing one must not re-arm
    wr_reg(8'hA2, 8'h80);
    cmd_wait(1, 600, 600);
    // Host side re-arms with zero then one
    wr_reg(8'hA2, 8'h00);
    wr_reg(8'hA2, 8'h90);
    cmd_wait(1, 1021, 1100);
    wr_reg(8'hA2, 8'h00);
    wr_reg(8'hA2, 8'h80);
    pulse(1'b1);
    chk_reg(8'hA2, 8'h82);
    wr_reg(8'hA2, 8'h00);
    cmd_wait(0, 600, 600);
    cmd_wait(1, 600, 600);
  endtask
  initial begin
    {rstn, wr, rd, fault, cmd, cool, latch, wp} = '0;
    {addr, wdata, k} = '0;
    lat = 4'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_log();
    t_restart();
    conclude();
  end
endmodule // tb_top
bind flarc_top flarc_top_asserts #(.CYC_PER_MS(CYC_PER_MS)) flarc_top_asserts_inst (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .EE_WR_REQ_O(EE_WR_REQ_O), .EE_ADDR_O(EE_ADDR_O), .EE_DATA_O(EE_DATA_O), .EE_WR_ACK_I(EE_WR_ACK_I),
  .LOG_ALERT_O(LOG_ALERT_O), .RESTART_CMD_I(RESTART_CMD_I), .WP_PIN_I(WP_PIN_I), .RESTART_O(RESTART_O));
